// file: cpu_seq_model.sv
// behavioural cpu sequencer facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic long_call,
  input  wire logic call_active,
  input  wire logic slow,
  output var  logic instr_boundary,
  output var  logic call_taken
);
  logic [1:0] cnt;
  // ------------------------------------------------------------
  // instruction stream and call acceptance
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      instr_boundary <= 1'b0;
      call_taken <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      // no instruction completes while a call is made
      instr_boundary <= cnt[0] && !long_call && !call_active && !call_taken;
      call_taken <= long_call && !call_taken && (!slow || cnt == 2'h3);
    end
  end
endmodule
`default_nettype wire

// file: irq_unit.v
// two-level vectored interrupt unit with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_map.vh"

module irq_unit (
  input  wire        clk,
  input  wire        rst_n,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pending flags, one level per flag, from peripherals
  input  wire        ext0_pending,
  input  wire        timer0_overflow_pending,
  input  wire        ext1_pending,
  input  wire        timer1_overflow_pending,
  input  wire        serial_receive_pending,
  input  wire        serial_transmit_pending,
  input  wire        timer2_high_overflow_pending,
  input  wire        timer2_low_overflow_pending,
  input  wire        sync_serial_done_pending,
  input  wire        sync_serial_write_collision,
  input  wire        sync_serial_mode_fault,
  input  wire        sync_serial_receive_overrun,
  input  wire        twowire_pending,
  input  wire        window_compare_pending,
  input  wire        conversion_done_pending,
  input  wire        counter_array_overflow_pending,
  input  wire [4:0]  counter_module_pending,
  input  wire        counter_pwm_overflow_pending,
  input  wire        comparator0_fall_pending,
  input  wire        comparator0_rise_pending,
  input  wire        comparator1_fall_pending,
  input  wire        comparator1_rise_pending,
  input  wire        timer3_high_overflow_pending,
  input  wire        timer3_low_overflow_pending,
  // cpu sequencer
  input  wire        instr_boundary,
  input  wire        next_multi_cycle,
  input  wire        return_from_interrupt,
  output wire        long_call,
  output reg  [15:0] vector_address,
  output reg  [3:0]  vector_order,
  input  wire        call_taken,
  output reg         call_active,
  output wire        ext0_clear,
  output wire        timer0_clear,
  output wire        ext1_clear,
  output wire        timer1_clear,
  output wire        service_low_active,
  output wire        service_high_active
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // vector of an order number
  function [15:0] order_vector;
    input [3:0] ord;
    begin
      order_vector = `VECTOR_BASE + ({12'h000, ord} << `VECTOR_STEP_SHIFT);
    end
  endfunction

  // lowest set bit of a 15-bit request set, none if empty
  function [3:0] first_order;
    input [14:0] set;
    integer k;
    begin
      first_order = `ORDER_NONE;
      for (k = `NUM_ORDERS - 1; k >= 0; k = k - 1) begin
        if (set[k]) first_order = k[3:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0]  enable_primary;
  reg  [7:0]  priority_primary;
  reg  [7:0]  enable_extended;
  reg  [7:0]  priority_extended;
  reg         service_low;
  reg         service_high;
  reg         call_pending;
  reg         post_return;
  reg         enable_cleared;
  reg  [`CNT_W-1:0] call_count;

  // ----------------------------------------------------------------
  // source combining and per-order maps
  // ----------------------------------------------------------------
  wire [14:0] pending;
  wire [14:0] enables;
  wire [14:0] levels;
  wire [14:0] request;
  wire        global_irq_enable;

  assign pending[0]  = ext0_pending;
  assign pending[1]  = timer0_overflow_pending;
  assign pending[2]  = ext1_pending;
  assign pending[3]  = timer1_overflow_pending;
  assign pending[4]  = serial_receive_pending | serial_transmit_pending;
  assign pending[5]  = timer2_high_overflow_pending | timer2_low_overflow_pending;
  assign pending[6]  = sync_serial_done_pending | sync_serial_write_collision
                     | sync_serial_mode_fault | sync_serial_receive_overrun;
  assign pending[7]  = twowire_pending;
  assign pending[8]  = 1'b0;
  assign pending[9]  = window_compare_pending;
  assign pending[10] = conversion_done_pending;
  assign pending[11] = counter_array_overflow_pending | (|counter_module_pending)
                     | counter_pwm_overflow_pending;
  assign pending[12] = comparator0_fall_pending | comparator0_rise_pending;
  assign pending[13] = comparator1_fall_pending | comparator1_rise_pending;
  assign pending[14] = timer3_high_overflow_pending | timer3_low_overflow_pending;

  assign global_irq_enable = enable_primary[`GLOBAL_ENABLE_BIT];
  // orders 0..6 in primary, 7 at extended bit 0, 9..14 at extended bits 2..7
  assign enables = {enable_extended[7:2], 1'b0, enable_extended[0], enable_primary[6:0]};
  assign levels  = {priority_extended[7:2], 1'b0, priority_extended[0], priority_primary[6:0]};

  genvar g;
  generate
    for (g = 0; g < `NUM_ORDERS; g = g + 1) begin : gen_req
      assign request[g] = pending[g] & enables[g] & global_irq_enable;
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration, decoded every cycle
  // ----------------------------------------------------------------
  wire [14:0] high_req = request & levels;
  wire [14:0] low_req  = request & ~levels;
  wire [3:0]  high_win = first_order(high_req);
  wire [3:0]  low_win  = first_order(low_req);
  wire        high_ok  = (|high_req) & ~service_high;
  wire        low_ok   = (|low_req) & ~service_high & ~service_low;
  wire [3:0]  winner   = high_ok ? high_win : low_win;
  wire        can_take = (high_ok | low_ok) & instr_boundary & ~post_return & ~call_pending
                       & ~call_active & ~(enable_cleared & next_multi_cycle);

  assign long_call = call_pending;
  assign service_low_active  = service_low;
  assign service_high_active = service_high;

  wire clear_pulse = call_pending & call_taken;
  assign ext0_clear   = clear_pulse & (vector_order == 4'h0);
  assign timer0_clear = clear_pulse & (vector_order == 4'h1);
  assign ext1_clear   = clear_pulse & (vector_order == 4'h2);
  assign timer1_clear = clear_pulse & (vector_order == 4'h3);

  // ----------------------------------------------------------------
  // call sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      call_pending   <= 1'b0;
      call_active    <= 1'b0;
      call_count     <= {`CNT_W{1'b0}};
      vector_address <= 16'h0000;
      vector_order   <= `ORDER_NONE;
      service_low    <= 1'b0;
      service_high   <= 1'b0;
      post_return    <= 1'b0;
    end else begin
      if (can_take) begin
        call_pending   <= 1'b1;
        vector_address <= order_vector(winner);
        vector_order   <= winner;
      end else if (clear_pulse) begin
        call_pending <= 1'b0;
        call_active  <= 1'b1;
        call_count   <= `CALL_CYCLES - `DETECT_CYCLES;
        if (high_ok_latched(vector_order)) service_high <= 1'b1;
        else service_low <= 1'b1;
      end else if (call_active) begin
        if (call_count == `DETECT_CYCLES) call_active <= 1'b0;
        call_count <= call_count - `DETECT_CYCLES;
      end
      if (return_from_interrupt) begin
        // drop the innermost level and hold one instruction before re-entry
        if (service_high) service_high <= 1'b0;
        else service_low <= 1'b0;
        post_return <= 1'b1;
      end else if (post_return & instr_boundary) begin
        post_return <= 1'b0;
      end
    end
  end

  // level of the order being vectored
  function high_ok_latched;
    input [3:0] ord;
    begin
      high_ok_latched = levels[ord];
    end
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [3:0]  aw_addr;
  reg [7:0]  w_byte;
  reg        w_lane;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  wire do_write = aw_held & w_held;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 4'h0;
      w_byte            <= 8'h00;
      w_lane            <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= `RESP_OKAY;
      enable_primary    <= `REG_RESET;
      priority_primary  <= `REG_RESET;
      enable_extended   <= `REG_RESET;
      priority_extended <= `REG_RESET;
      enable_cleared    <= 1'b0;
    end else begin
      enable_cleared <= instr_boundary ? 1'b0 : enable_cleared;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr)
          `ADDR_ENABLE_PRIMARY: begin
            if (w_lane) begin
              enable_primary <= w_byte;
              if (|(enable_primary & ~w_byte)) enable_cleared <= 1'b1;
            end
          end
          `ADDR_PRIORITY_PRIMARY: begin
            if (w_lane) priority_primary <= {1'b0, w_byte[6:0]};
          end
          `ADDR_ENABLE_EXTENDED: begin
            if (w_lane) begin
              enable_extended <= w_byte;
              if (|(enable_extended & ~w_byte)) enable_cleared <= 1'b1;
            end
          end
          `ADDR_PRIORITY_EXTENDED: begin
            if (w_lane) priority_extended <= w_byte;
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_ENABLE_PRIMARY:    s_axi_rdata <= {24'h000000, enable_primary};
          `ADDR_PRIORITY_PRIMARY:  s_axi_rdata <= {24'h000000, priority_primary | `PRIORITY_PRIMARY_READ1};
          `ADDR_ENABLE_EXTENDED:   s_axi_rdata <= {24'h000000, enable_extended};
          `ADDR_PRIORITY_EXTENDED: s_axi_rdata <= {24'h000000, priority_extended};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: irq_unit_chk.sv
// concurrent checks on the interrupt unit sequencer ports
`timescale 1ns/1ps
`default_nettype none
module irq_unit_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        instr_boundary,
  input wire logic        long_call,
  input wire logic [15:0] vector_address,
  input wire logic [3:0]  vector_order,
  input wire logic        call_taken,
  input wire logic        call_active,
  input wire logic        ext0_clear,
  input wire logic        timer0_clear,
  input wire logic        ext1_clear,
  input wire logic        timer1_clear,
  input wire logic        service_low_active,
  input wire logic        service_high_active
);
  // ------------------------------------------------------------
  // call handshake, vectors and levels
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = long_call && call_taken;

  a_call_at_boundary: assert property ($rose(long_call) |-> $past(instr_boundary))
    else $error("long call raised without an instruction boundary");
  a_call_held: assert property (long_call && !call_taken |=> long_call)
    else $error("long call dropped before acceptance");
  a_call_length: assert property (take |=> call_active [*3] ##1 !call_active)
    else $error("call did not last four cycles");
  a_vector_map: assert property (long_call |-> vector_address == 16'h0003 + {9'h000, vector_order, 3'h0})
    else $error("vector address does not match order");
  a_no_reserved: assert property (long_call |-> vector_order != 4'h8 && vector_order != 4'hF)
    else $error("reserved or empty order vectored");
  a_hw_clear: assert property (ext0_clear == (take && vector_order == 4'h0)
    && timer0_clear == (take && vector_order == 4'h1) && ext1_clear == (take && vector_order == 4'h2)
    && timer1_clear == (take && vector_order == 4'h3))
    else $error("flag clear pulse wrong");
  a_level_set: assert property (take |-> ##2 (service_low_active || service_high_active))
    else $error("no service level after call");
  a_high_kept: assert property ($rose(long_call) |-> !$past(service_high_active))
    else $error("high routine preempted");
  a_no_overlap: assert property ($rose(long_call) |-> !$past(call_active))
    else $error("new call during call");

  c_preempt: cover property ($rose(long_call) && service_low_active);
  c_high: cover property ($rose(service_high_active));
  c_timer3: cover property (take && vector_order == 4'hE);
endmodule
bind irq_unit irq_unit_chk i_chk (.clk, .rst_n, .instr_boundary, .long_call, .vector_address, .vector_order,
  .call_taken, .call_active, .ext0_clear, .timer0_clear, .ext1_clear, .timer1_clear, .service_low_active,
  .service_high_active);
`default_nettype wire

// file: irq_unit_map.vh
// register map, field positions and timing constants of the interrupt unit
//
// Behaviour
// - fourteen sources, each assignable to low or high priority level
// - a trigger sets the pending flag whether or not the source is enabled
// - enabled pending source: finish current instruction, then long call to its vector
// - return from interrupt resumes at the instruction that would have run next
// - pending flag of a disabled source has no effect on program flow
// - global enable bit 7 gates every individual enable
// - enable cleared before a multi-cycle instruction blocks requests posted meanwhile
// - vectoring clears external 0/1 and timer 0/1 flags; others stay set
// - flag still set after return raises a new request after one more instruction
// - software setting a pending flag requests exactly like hardware
// - high preempts low; high never preempted; all default low
// - higher level wins; equal level lowest order number wins
// - decode every cycle; fastest response 5 cycles, detect 1 plus call 4
// - worst response 18 cycles: detect 1, return 5, divide 8, call 4
// - after return, exactly one more instruction runs before the next long call
// - request not above the running level waits for return plus one instruction
// - vectors from 0x0003 stepping 8 to 0x0073; slot 0x0043 reserved
// - order numbers map to the fixed list of peripherals
// - a source with several flags requests while any flag is set
// - enable bit positions in primary and extended enable registers
// - priority bits at the same positions as the enable bits; one is high
`ifndef IRQ_UNIT_MAP_VH
`define IRQ_UNIT_MAP_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_ENABLE_PRIMARY    4'h0
`define ADDR_PRIORITY_PRIMARY  4'h4
`define ADDR_ENABLE_EXTENDED   4'h8
`define ADDR_PRIORITY_EXTENDED 4'hC

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define GLOBAL_ENABLE_BIT      7
`define PRIORITY_PRIMARY_READ1 8'h80
`define RESERVED_EXT_BIT       1
`define REG_RESET              8'h00
`define NUM_ORDERS             15
`define RESERVED_ORDER         4'h8
`define ORDER_NONE             4'hF

// ----------------------------------------------------------------
// vectors
// ----------------------------------------------------------------
`define VECTOR_BASE            16'h0003
`define VECTOR_STEP_SHIFT      3

// ----------------------------------------------------------------
// timing in cycles
// ----------------------------------------------------------------
`define DETECT_CYCLES          4'h1
`define CALL_CYCLES            4'h4
`define CNT_W                  4

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// file: irq_unit_tb.sv
// self-checking bench for the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module irq_unit_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, vector_order;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h40;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, return_from_interrupt = 1'b0, next_multi_cycle = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        instr_boundary, call_taken, long_call, call_active, alt = 1'b0, slow = 1'b0;
  logic        ext0_clear, timer0_clear, ext1_clear, timer1_clear, service_low_active, service_high_active;
  logic [15:0] vector_address;
  logic [14:0] flag = 15'h0;
  int          n_mismatch, samples_checked, n_take, want, cyc;
  logic [19:0] exp_vec[$];
  logic [33:0] exp_rd[$];
  logic [1:0]  exp_wr[$];

  always #10 clk = ~clk;

  irq_unit i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext0_pending(flag[0]),
    .timer0_overflow_pending(flag[1]), .ext1_pending(flag[2]), .timer1_overflow_pending(flag[3]),
    .serial_receive_pending(flag[4] & alt), .serial_transmit_pending(flag[4] & !alt),
    .timer2_high_overflow_pending(flag[5] & alt), .timer2_low_overflow_pending(flag[5] & !alt),
    .sync_serial_done_pending(flag[6] & alt & !slow), .sync_serial_write_collision(flag[6] & !alt & !slow),
    .sync_serial_mode_fault(flag[6] & alt & slow), .sync_serial_receive_overrun(flag[6] & !alt & slow),
    .twowire_pending(flag[7]), .window_compare_pending(flag[9]), .conversion_done_pending(flag[10]),
    .counter_array_overflow_pending(flag[11] & alt & !slow), .counter_module_pending({flag[11] & !alt & slow,
    3'h0, flag[11] & !alt & !slow}), .counter_pwm_overflow_pending(flag[11] & alt & slow),
    .comparator0_fall_pending(flag[12] & alt),
    .comparator0_rise_pending(flag[12] & !alt), .comparator1_fall_pending(flag[13] & alt),
    .comparator1_rise_pending(flag[13] & !alt), .timer3_high_overflow_pending(flag[14] & alt),
    .timer3_low_overflow_pending(flag[14] & !alt), .instr_boundary, .next_multi_cycle, .return_from_interrupt,
    .long_call, .vector_address, .vector_order, .call_taken, .call_active, .ext0_clear, .timer0_clear,
    .ext1_clear, .timer1_clear, .service_low_active, .service_high_active);

  cpu_seq_model i_cpu (.clk, .rst_n, .long_call, .call_active, .slow, .instr_boundary, .call_taken);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // high level first, then lowest order
  function automatic logic [3:0] winner(input logic [14:0] p, input logic [14:0] h);
    logic [14:0] m;
    m = ((p & h) != 15'h0) ? (p & h) : p;
    for (int i = 14; i >= 0; i--) if (m[i]) winner = i[3:0];
  endfunction

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_vec(input logic [19:0] g);
    logic [19:0] e;
    e = exp_vec.size() ? exp_vec.pop_front() : 20'hFFFFF;
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: vector %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_rd(input logic [33:0] g);
    logic [33:0] e;
    e = exp_rd.size() ? exp_rd.pop_front() : '1;
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_wr(input logic [1:0] g);
    logic [1:0] e;
    e = exp_wr.size() ? exp_wr.pop_front() : 2'b11;
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: write response %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
    exp_wr.push_back(2'b00);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [33:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic serve(input logic [3:0] o);
    exp_vec.push_back({o, 16'h0003 + {9'h000, o, 3'h0}});
    want++;
  endtask

  // routine body: wait for call k, clear own flag if order above 3, return
  task automatic finish(input logic [3:0] o, input int k);
    while (n_take < k) @(posedge clk);
    repeat (4) @(posedge clk);
    if (o > 4'h3) flag[o] <= 1'b0;
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // monitor, peripheral clears, timeout
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    next_multi_cycle <= cyc[2];
    if (|{timer1_clear, ext1_clear, timer0_clear, ext0_clear})
      flag[3:0] <= flag[3:0] & ~{timer1_clear, ext1_clear, timer0_clear, ext0_clear};
    if (long_call && call_taken) begin
      n_take++;
      cmp_vec({vector_order, vector_address});
    end
    if (s_axi_rvalid && s_axi_rready)
      cmp_rd({s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      cmp_wr(s_axi_bresp);
    if (cyc == 10000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] r;
    logic [14:0] hp, p;
    logic [3:0]  o;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(4'h0, 34'h0);
    axi_rd(4'h4, 34'h80);
    axi_rd(4'h8, 34'h0);
    axi_rd(4'hC, 34'h0);
    axi_rd(4'h2, {2'b10, 32'h0});
    flag[1] <= 1'b1;
    flag[9] <= 1'b1;
    axi_wr(4'h0, 8'h02);
    repeat (20) @(posedge clk);
    serve(4'h1);
    axi_wr(4'h0, 8'h82);
    finish(4'h1, want);
    axi_rd(4'h0, 34'h82);
    flag[9] <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      axi_wr(4'h0, 8'h00);
      r = xs();
      hp = r[30:16] & 15'h7EFF;
      p = (r[14:0] & 15'h7EFF) | 15'h0001;
      alt <= r[15];
      slow <= r[31];
      axi_wr(4'h4, {1'b0, hp[6:0]});
      axi_wr(4'hC, {hp[14:9], 1'b0, hp[7]});
      axi_wr(4'h8, 8'hFD);
      flag <= p;
      o = winner(p, hp);
      serve(o);
      axi_wr(4'h0, 8'hFF);
      while (p != 15'h0) begin
        finish(o, want);
        p[o] = 1'b0;
        if (p != 15'h0) begin
          o = winner(p, hp);
          serve(o);
        end
      end
    end
    axi_wr(4'h4, 8'h00);
    axi_wr(4'hC, 8'h04);
    axi_wr(4'h8, 8'h04);
    serve(4'h4);
    flag <= 15'h0010;
    axi_wr(4'h0, 8'hB0);
    while (n_take < want) @(posedge clk);
    serve(4'h9);
    serve(4'h5);
    flag[9] <= 1'b1;
    flag[5] <= 1'b1;
    finish(4'h9, want - 1);
    finish(4'h4, want - 1);
    finish(4'h5, want);
    axi_wr(4'h0, 8'h00);
    axi_rd(4'hC, 34'h04);
    repeat (20) @(posedge clk);
    // nothing may remain unserved
    cmp_vec(20'hFFFFF);
    print_verdict();
  end
endmodule
`default_nettype wire
